// File: include/pwr_seq_pkg.sv
/*
 power sequencer constants: mode encodings, power states, timing counts.
 assumes a 100 MHz clk for every module that uses it.
*/
//
// Operation
// - bits 00, standby low: off when idle
// - bits 00, standby high: always powered
// - bits 01 up, 10 off, 11 partial
// - bits 11: partial down when not converting
// - full down all off; partial keeps reference
// - controller keeps bits zero using standby
// - controller holds standby low for slow rates
// - software-only control holds standby high
// - autocalibration ignores standby, stays powered
// - calibration request high skips autocalibration
// - controller idles 32 ms after power-on
// - wake from full down in 5 us
// - between-conversions mode: off when busy falls
// - trigger falling edge starts power-up
// - trigger rising edge starts conversion
// - controller holds trigger low 5 us
// - separate power-up write before software conversion
// - no automatic partial down after calibration
// - three writes for calibration in partial mode
// - conversion takes 4.6 us at 4 MHz
// - busy high for whole calibration
package pwr_seq_pkg;

	typedef enum logic [1:0] {
		PM_AUTO    = 2'h0,
		PM_UP      = 2'h1,
		PM_OFF     = 2'h2,
		PM_PARTIAL = 2'h3
	} pmode_e;

	typedef enum logic [1:0] {
		PWR_ON      = 2'h0,
		PWR_PARTIAL = 2'h1,
		PWR_OFF     = 2'h2
	} pstate_e;

	localparam int CLK_MHZ        = 100;
	localparam int WAKE_NS        = 5000;
	localparam int CONV_NS        = 4600;
	localparam int AUTOCAL_US     = 32000;
	localparam int TRIMCAL_US     = 31250;
	localparam int WAKE_CYC       = (WAKE_NS * CLK_MHZ) / 1000;
	localparam int CONV_CYC       = (CONV_NS * CLK_MHZ) / 1000;
	localparam int AUTOCAL_CYC    = AUTOCAL_US * CLK_MHZ;
	localparam int TRIMCAL_CYC    = TRIMCAL_US * CLK_MHZ;
	localparam int CNT_W          = 24;
	localparam int WAKE_MARGIN    = 2;

	// controller register map (APB, byte addresses)
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_CMD    = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam int CTRL_STANDBY  = 0;
	localparam int CTRL_PM_LO    = 1;
	localparam int CTRL_PM_HI    = 2;
	localparam int CMD_CONV      = 0;
	localparam int CMD_TRIM      = 1;
	localparam int CMD_WRPM      = 2;
	localparam int ST_BUSY       = 0;
	localparam int ST_PWR_LO     = 1;
	localparam int ST_CMD_ACT    = 3;
	localparam int ST_CAL_DONE   = 4;

endpackage

// File: include/pwr_link_if.sv
/*
 pins between the converter's power sequencer and its controller.
 assumes both ends share clk; the device samples pins through synchronisers.
*/
`timescale 1ns/1ps
interface pwr_link_if;
	logic       conversion_trigger_n;
	logic       standby_n;
	logic       cal_request_n;
	logic       power_mgmt_hi_bit;
	logic       power_mgmt_lo_bit;
	logic       trim_start_bit;
	logic       ctrl_write;
	logic       busy;

	modport device (
		input  conversion_trigger_n,
		input  standby_n,
		input  cal_request_n,
		input  power_mgmt_hi_bit,
		input  power_mgmt_lo_bit,
		input  trim_start_bit,
		input  ctrl_write,
		output busy
	);

	modport host (
		output conversion_trigger_n,
		output standby_n,
		output cal_request_n,
		output power_mgmt_hi_bit,
		output power_mgmt_lo_bit,
		output trim_start_bit,
		output ctrl_write,
		input  busy
	);
endinterface

// File: core/pin_sync.sv
/*
 two-flop synchroniser for a group of pin levels.
 assumes pins are asynchronous to clk; output is two edges late.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} state_s;

	state_s st_q;
	state_s st_d;

	always_comb begin
		st_d      = st_q;
		st_d.meta = pinIn;
		st_d.sync = st_q.meta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '{meta: INIT, sync: INIT};
		end else begin
			st_q <= st_d;
		end
	end

	assign pinOut = st_q.sync;
endmodule // pin_sync

// File: core/adc_power_management.sv
/*
 device end: power state sequencer of the sampling converter.
 assumes link pins come from another domain; the pm bits and trim bit are
 taken on the rising edge of the ctrl write strobe, after synchronisation.
 boot waits for the synchroniser, so the cal request level is the pin's own.
*/
`timescale 1ns/1ps
module adc_power_management #(
	parameter int AUTOCAL_CYCLES = pwr_seq_pkg::AUTOCAL_CYC,
	parameter int TRIMCAL_CYCLES = pwr_seq_pkg::TRIMCAL_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	pwr_link_if.device      link,
	output logic [1:0]      powerState,
	output logic            refPowered,
	output logic            coreRunning,
	output logic            calActive
);
	typedef enum logic [2:0] {S_BOOT, S_AUTOCAL, S_IDLE, S_WAKE, S_WAIT_RISE,
		S_CONV, S_TRIM} phase_e;

	typedef struct packed {
		phase_e                          phase;
		pwr_seq_pkg::pmode_e             mode;
		pwr_seq_pkg::pstate_e            pwr;
		logic [pwr_seq_pkg::CNT_W-1:0]   cnt;
		logic                            trigPrev;
		logic                            wrPrev;
		logic                            busy;
		logic                            trimPend;
		logic [1:0]                      bootWait;
		logic                            refOn;
		logic                            coreOn;
		logic                            calOn;
	} state_s;

	state_s st_q;
	state_s st_d;

	logic       trigN;
	logic       sbN;
	logic       calN;
	logic       pmHi;
	logic       pmLo;
	logic       trimB;
	logic       wrS;

	// trigger, standby and cal request idle high, all else low
	// matching idle levels: no false edge or stray strobe after reset
	pin_sync #(.W(7), .INIT(7'h07)) u_sync (
		.clk    (clk),
		.nrst   (nrst),
		.pinIn  ({link.ctrl_write, link.trim_start_bit, link.power_mgmt_lo_bit,
			link.power_mgmt_hi_bit, link.cal_request_n, link.standby_n,
			link.conversion_trigger_n}),
		.pinOut ({wrS, trimB, pmLo, pmHi, calN, sbN, trigN})
	);

	// idle power level chosen from current mode and standby level
	function automatic pwr_seq_pkg::pstate_e idle_level(pwr_seq_pkg::pmode_e m, logic sb);
		unique case (m)
			pwr_seq_pkg::PM_AUTO:    idle_level = sb ? pwr_seq_pkg::PWR_ON
				: pwr_seq_pkg::PWR_OFF;
			pwr_seq_pkg::PM_UP:      idle_level = pwr_seq_pkg::PWR_ON;
			pwr_seq_pkg::PM_OFF:     idle_level = pwr_seq_pkg::PWR_OFF;
			pwr_seq_pkg::PM_PARTIAL: idle_level = pwr_seq_pkg::PWR_PARTIAL;
		endcase
	endfunction

	logic trigFall;
	logic trigRise;
	logic wrPulse;
	assign trigFall = st_q.trigPrev & ~trigN;
	assign trigRise = ~st_q.trigPrev & trigN;
	assign wrPulse  = wrS & ~st_q.wrPrev;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d          = st_q;
		st_d.trigPrev = trigN;
		st_d.wrPrev   = wrS;
		// mode taken only on the strobe edge; bare levels change nothing
		if (wrPulse) begin
			st_d.mode = pwr_seq_pkg::pmode_e'({pmHi, pmLo});
			if (trimB) begin
				st_d.trimPend = 1'b1;
			end
		end
		unique case (st_q.phase)
			S_BOOT: begin
				// sync stages fill before the request pin is trusted
				st_d.bootWait = {st_q.bootWait[0], 1'b1};
				if (!st_q.bootWait[1]) begin
					st_d.phase = S_BOOT;
				end else if (calN) begin
					st_d.phase = S_IDLE;
				end else begin
					st_d.phase = S_AUTOCAL;
					st_d.cnt   = pwr_seq_pkg::CNT_W'(AUTOCAL_CYCLES);
					st_d.busy  = 1'b1;
					st_d.pwr   = pwr_seq_pkg::PWR_ON;
				end
			end
			S_AUTOCAL: begin
				if (st_q.cnt == '0) begin
					st_d.phase = S_IDLE;
					st_d.busy  = 1'b0;
				end else begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			S_IDLE: begin
				st_d.pwr = idle_level(st_q.mode, sbN);
				if (st_q.trimPend) begin
					// a trim strobed in this cycle stays pending
					st_d.trimPend = wrPulse & trimB;
					st_d.phase    = S_TRIM;
					st_d.cnt      = pwr_seq_pkg::CNT_W'(TRIMCAL_CYCLES);
					st_d.busy     = 1'b1;
					st_d.pwr      = pwr_seq_pkg::PWR_ON;
				end else if (trigFall) begin
					st_d.phase = (st_q.pwr == pwr_seq_pkg::PWR_ON) ? S_WAIT_RISE : S_WAKE;
					st_d.cnt   = pwr_seq_pkg::CNT_W'(pwr_seq_pkg::WAKE_CYC - 1);
					st_d.pwr   = pwr_seq_pkg::PWR_ON;
				end
			end
			S_WAKE: begin
				// early rise cuts the wake short; the host owns the low time
				if (trigRise) begin
					st_d.phase = S_CONV;
					st_d.cnt   = pwr_seq_pkg::CNT_W'(pwr_seq_pkg::CONV_CYC - 1);
					st_d.busy  = 1'b1;
				end else if (st_q.cnt == '0) begin
					st_d.phase = S_WAIT_RISE;
				end else begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			S_WAIT_RISE: begin
				if (trigRise) begin
					st_d.phase = S_CONV;
					st_d.cnt   = pwr_seq_pkg::CNT_W'(pwr_seq_pkg::CONV_CYC - 1);
					st_d.busy  = 1'b1;
				end
			end
			S_CONV: begin
				if (st_q.cnt == '0) begin
					st_d.phase = S_IDLE;
					st_d.busy  = 1'b0;
					st_d.pwr   = idle_level(st_q.mode, sbN);
				end else begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			S_TRIM: begin
				if (st_q.cnt == '0) begin
					st_d.phase = S_IDLE;
					st_d.busy  = 1'b0;
					if (!wrPulse && st_q.mode == pwr_seq_pkg::PM_PARTIAL) begin
						st_d.mode = pwr_seq_pkg::PM_UP;
					end
				end else begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			default: st_d.phase = S_IDLE;
		endcase
		st_d.refOn  = st_d.pwr != pwr_seq_pkg::PWR_OFF;
		st_d.coreOn = st_d.pwr == pwr_seq_pkg::PWR_ON;
		st_d.calOn  = (st_d.phase == S_AUTOCAL) | (st_d.phase == S_TRIM);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '{phase: S_BOOT, mode: pwr_seq_pkg::PM_AUTO, pwr: pwr_seq_pkg::PWR_ON,
				cnt: '0, trigPrev: 1'b1, wrPrev: 1'b0, busy: 1'b0, trimPend: 1'b0,
				bootWait: 2'h0, refOn: 1'b1, coreOn: 1'b1, calOn: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.busy   = st_q.busy;
	assign powerState  = st_q.pwr;
	assign refPowered  = st_q.refOn;
	assign coreRunning = st_q.coreOn;
	assign calActive   = st_q.calOn;
endmodule // adc_power_management

// File: core/adc_power_host.sv
/*
 host end: APB slave taking orders, driving pins of the power sequencer.
 assumes busy is from the device clock domain and synchronises it.
*/
`timescale 1ns/1ps
module adc_power_host (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [3:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	pwr_link_if.host         link
);
	typedef enum logic [1:0] {H_IDLE, H_WRITE, H_TRIG_LOW, H_TRIG_HIGH} hphase_e;

	typedef struct packed {
		hphase_e                        phase;
		logic                           standbyN;
		logic [1:0]                     pm;
		logic                           trim;
		logic                           wr;
		logic                           trigN;
		logic [pwr_seq_pkg::CNT_W-1:0]  cnt;
		logic                           calDone;
		logic [31:0]                    rdata;
		logic                           ready;
		logic                           err;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic   busyS;

	pin_sync #(.W(1), .INIT(1'b0)) u_busy (
		.clk    (clk),
		.nrst   (nrst),
		.pinIn  (link.busy),
		.pinOut (busyS)
	);

	logic access;
	assign access = psel & penable & ~st_q.ready;

	always_comb begin
		st_d       = st_q;
		st_d.ready = 1'b0;
		st_d.err   = 1'b0;
		st_d.wr    = 1'b0;
		if (busyS) begin
			st_d.calDone = 1'b0;
		end
		if (access) begin
			st_d.ready = 1'b1;
			st_d.rdata = '0;
			if (pwrite) begin
				unique case (paddr)
					pwr_seq_pkg::ADDR_CTRL: begin
						// standby mode leaves bits zero by default
						st_d.standbyN = pwdata[pwr_seq_pkg::CTRL_STANDBY];
						st_d.pm = {pwdata[pwr_seq_pkg::CTRL_PM_HI],
							pwdata[pwr_seq_pkg::CTRL_PM_LO]};
					end
					pwr_seq_pkg::ADDR_CMD: begin
						if (st_q.phase != H_IDLE) begin
							st_d.err = 1'b1;
						end else if (pwdata[pwr_seq_pkg::CMD_CONV]) begin
							st_d.phase = H_TRIG_LOW;
							st_d.trigN = 1'b0;
							// trigger low long enough to wake
							st_d.cnt = pwr_seq_pkg::CNT_W'(pwr_seq_pkg::WAKE_CYC
								+ pwr_seq_pkg::WAKE_MARGIN);
						end else if (pwdata[pwr_seq_pkg::CMD_TRIM]
							| pwdata[pwr_seq_pkg::CMD_WRPM]) begin
							// each write is its own frame
							st_d.trim  = pwdata[pwr_seq_pkg::CMD_TRIM];
							st_d.phase = H_WRITE;
							st_d.cnt   = pwr_seq_pkg::CNT_W'(pwr_seq_pkg::WAKE_MARGIN);
						end
					end
					pwr_seq_pkg::ADDR_STATUS: st_d.err = 1'b0;
					default: st_d.err = 1'b1;
				endcase
			end else begin
				unique case (paddr)
					pwr_seq_pkg::ADDR_CTRL: st_d.rdata = 32'({st_q.pm, st_q.standbyN});
					pwr_seq_pkg::ADDR_CMD: st_d.rdata = '0;
					pwr_seq_pkg::ADDR_STATUS: st_d.rdata = 32'({st_q.calDone,
						st_q.phase != H_IDLE, 2'h0, busyS});
					default: st_d.err = 1'b1;
				endcase
			end
		end
		unique case (st_q.phase)
			H_IDLE: ;
			H_WRITE: begin
				// strobe held long enough for two-flop capture
				st_d.wr = 1'b1;
				if (st_q.cnt == '0) begin
					st_d.wr      = 1'b0;
					st_d.trim    = 1'b0;
					st_d.phase   = H_IDLE;
					st_d.calDone = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			H_TRIG_LOW: begin
				if (st_q.cnt == '0) begin
					st_d.trigN = 1'b1;
					st_d.phase = H_TRIG_HIGH;
				end else begin
					st_d.cnt = st_q.cnt - 1'b1;
				end
			end
			H_TRIG_HIGH: st_d.phase = H_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			// standby defaults high for software control
			st_q <= '{phase: H_IDLE, standbyN: 1'b1, pm: 2'h0, trim: 1'b0, wr: 1'b0,
				trigN: 1'b1, cnt: '0, calDone: 1'b0, rdata: '0, ready: 1'b0, err: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata                    = st_q.rdata;
	assign pready                    = st_q.ready;
	assign pslverr                   = st_q.err;
	assign link.standby_n            = st_q.standbyN;
	assign link.cal_request_n        = 1'b1;
	assign link.power_mgmt_hi_bit    = st_q.pm[1];
	assign link.power_mgmt_lo_bit    = st_q.pm[0];
	assign link.trim_start_bit       = st_q.trim;
	assign link.ctrl_write           = st_q.wr;
	assign link.conversion_trigger_n = st_q.trigN;
endmodule // adc_power_host

// File: sim/pwr_link_properties.sv
/*
 assertions on the power link pins and the device power outputs.
 assumes one clk domain; pins driven by the host end.
*/
`timescale 1ns/1ps
module pwr_link_properties (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       conversion_trigger_n,
	input wire logic       standby_n,
	input wire logic       power_mgmt_hi_bit,
	input wire logic       power_mgmt_lo_bit,
	input wire logic       ctrl_write,
	input wire logic       busy,
	input wire logic [1:0] powerState,
	input wire logic       refPowered,
	input wire logic       coreRunning,
	input wire logic       calActive
);
	logic [1:0] pmQ;
	logic       wrQ;
	logic       busyQ;
	logic       calQ;
	logic [9:0] lenQ;
	////////////////////////////////////////////////////////////////
	// bits as the device latches them; [*8] below covers sync delay
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pmQ   <= 2'h0;
			wrQ   <= 1'b0;
			busyQ <= 1'b0;
			calQ  <= 1'b0;
			lenQ  <= 10'h0;
		end else begin
			wrQ   <= ctrl_write;
			busyQ <= busy;
			calQ  <= calActive;
			lenQ  <= busy ? lenQ + 10'h1 : 10'h0;
			if (ctrl_write && !wrQ) begin
				pmQ <= {power_mgmt_hi_bit, power_mgmt_lo_bit};
			// partial mode falls back to full power after a trim
			end else if (busyQ && !busy && calQ && pmQ == 2'h3) begin
				pmQ <= 2'h1;
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_wake_on_fall: assert property ($fell(conversion_trigger_n) |->
		##[1:510] powerState == pwr_seq_pkg::PWR_ON) else $error("no wake after trigger fall");
	a_conv_start: assert property ($rose(conversion_trigger_n) |-> ##[1:8] busy)
		else $error("no busy after trigger rise");
	a_busy_length: assert property ($fell(busy) |-> lenQ inside {[459:461], [50:52]})
		else $error("busy length wrong");
	a_sleep_off: assert property ((pmQ == 2'h0 && !standby_n && !busy
		&& conversion_trigger_n)[*8] |-> powerState == pwr_seq_pkg::PWR_OFF && !refPowered)
		else $error("not off in sleep");
	a_awake_on: assert property ((pmQ == 2'h0 && standby_n)[*8]
		|-> powerState == pwr_seq_pkg::PWR_ON) else $error("not on when awake");
	a_mode_up: assert property ((pmQ == 2'h1)[*8] |-> powerState == pwr_seq_pkg::PWR_ON)
		else $error("not on in up mode");
	a_mode_off: assert property ((pmQ == 2'h2 && !busy && conversion_trigger_n)[*8]
		|-> powerState == pwr_seq_pkg::PWR_OFF && !refPowered) else $error("not off");
	a_partial_ref: assert property ((pmQ == 2'h3 && !busy && conversion_trigger_n)[*8]
		|-> powerState == pwr_seq_pkg::PWR_PARTIAL && refPowered) else $error("not partial");
	a_busy_powered: assert property (busy |-> powerState == pwr_seq_pkg::PWR_ON
		&& coreRunning) else $error("busy while powered down");
	a_auto_off_end: assert property ($fell(busy) && pmQ == 2'h0 && !standby_n
		|-> ##[0:3] powerState == pwr_seq_pkg::PWR_OFF) else $error("no off at busy fall");
	a_cal_busy: assert property (calActive |-> busy) else $error("cal without busy");
	a_trim_no_partial: assert property ($fell(calActive) && pmQ == 2'h3 |->
		(powerState == pwr_seq_pkg::PWR_ON)[*8]) else $error("partial after trim");
endmodule // pwr_link_properties

// File: sim/testbench.sv
/*
 testbench: APB orders into the host end, device end across the link.
 assumes calibration counts shortened to 50 cycles.
*/
`timescale 1ns/1ps
module testbench;
	logic        clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [3:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  powerState;
	logic        refPowered;
	logic        coreRunning;
	logic        calActive;
	logic [31:0] rd;
	logic        err;
	logic [2:0]  c;
	int          error_cnt;
	int          checked;
	int          seed;
	int          len;
	logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
	pwr_link_if link ();
	adc_power_management #(.AUTOCAL_CYCLES(50), .TRIMCAL_CYCLES(50)) i_adc_power_management (
		.clk(clk), .nrst(nrst), .link(link), .powerState(powerState),
		.refPowered(refPowered), .coreRunning(coreRunning), .calActive(calActive));
	adc_power_host i_adc_power_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	pwr_link_properties i_pwr_link_properties (.clk(clk), .nrst(nrst),
		.conversion_trigger_n(link.conversion_trigger_n), .standby_n(link.standby_n),
		.power_mgmt_hi_bit(link.power_mgmt_hi_bit), .power_mgmt_lo_bit(link.power_mgmt_lo_bit),
		.ctrl_write(link.ctrl_write), .busy(link.busy), .powerState(powerState),
		.refPowered(refPowered), .coreRunning(coreRunning), .calActive(calActive));
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d, checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// c = {pm hi, pm lo, standby_n}
	function automatic logic [1:0] expPwr(input logic [2:0] m);
		case (m[2:1])
			2'h0: return m[0] ? pwr_seq_pkg::PWR_ON : pwr_seq_pkg::PWR_OFF;
			2'h1: return pwr_seq_pkg::PWR_ON;
			2'h2: return pwr_seq_pkg::PWR_OFF;
			default: return pwr_seq_pkg::PWR_PARTIAL;
		endcase
	endfunction
	task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic waitBusy(input logic lvl);
		len = 0;
		while (link.busy !== lvl && len < 3000) begin
			@(posedge clk);
			len++;
		end
		if (len >= 3000) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic setMode(input logic [2:0] m);
		int i;
		apb(1'b1, pwr_seq_pkg::ADDR_CTRL, {29'h0, m});
		apb(1'b0, pwr_seq_pkg::ADDR_CTRL, 32'h0);
		check(rd, {29'h0, m});
		apb(1'b1, pwr_seq_pkg::ADDR_CMD, 32'h4);
		i = 0;
		do begin
			apb(1'b0, pwr_seq_pkg::ADDR_STATUS, 32'h0);
			i++;
		end while (rd[pwr_seq_pkg::ST_CMD_ACT] !== 1'b0 && i < 50);
		if (i >= 50) begin
			error_cnt++;
			summarize();
		end
		check(rd, 32'h1 << pwr_seq_pkg::ST_CAL_DONE);
		repeat (12) @(posedge clk);
		check(powerState, expPwr(m));
		check(refPowered, expPwr(m) != pwr_seq_pkg::PWR_OFF);
		check(coreRunning, expPwr(m) == pwr_seq_pkg::PWR_ON);
	endtask
	task automatic convert(input logic [2:0] m);
		apb(1'b1, pwr_seq_pkg::ADDR_CMD, 32'h1);
		apb(1'b1, pwr_seq_pkg::ADDR_CMD, 32'h4);
		check(err, 1'b1);
		waitBusy(1'b1);
		check(powerState, pwr_seq_pkg::PWR_ON);
		waitBusy(1'b0);
		check(len inside {[459:461]}, 1'b1);
		repeat (4) @(posedge clk);
		check(powerState, expPwr(m));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h0;
		error_cnt = 0;
		checked = 0;
		seed = 62677;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		// stay idle while an autocalibration could run
		repeat (60) @(posedge clk);
		check(link.busy, 1'b0);
		check(powerState, pwr_seq_pkg::PWR_ON);
		apb(1'b0, 4'hc, 32'h0);
		check(err, 1'b1);
		foreach (modes[k]) begin
			setMode(modes[k]);
			if (modes[k][2:1] != 2'h2)
				convert(modes[k]);
		end
		// trim in partial mode, then partial and up again
		setMode(3'h6);
		apb(1'b1, pwr_seq_pkg::ADDR_CMD, 32'h2);
		waitBusy(1'b1);
		check(calActive, 1'b1);
		waitBusy(1'b0);
		check(len inside {[50:52]}, 1'b1);
		repeat (4) @(posedge clk);
		check(powerState, pwr_seq_pkg::PWR_ON);
		setMode(3'h6);
		setMode(3'h2);
		repeat (6) begin
			c = 3'($random(seed));
			setMode(c);
			if (c[2:1] != 2'h2)
				convert(c);
		end
		summarize();
	end
endmodule // testbench
